/* File: logic/adc_control.sv */
// Converter control, pin select and AXI4-Lite register slave
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
// Summary of operation
// - Justify bit picks right or left result
// - Reference bit picks external pin or supply
// - Channel field routes one of four inputs
// - Pin select bit marks pin analog
// - Go bit starts; done clears it, flags
// - Clock select picks divider or RC
// - Conversion takes eleven conversion periods
// - Abort keeps result, waits two periods
module adc_control
    import adc_ctrl_pkg::*;
(
    input  wire logic        clk,             // 10 MHz system clock
    input  wire logic        rst_b,           // Async reset, active low
    input  wire logic [9:0]  s_axi_awaddr,    // Write address
    input  wire logic        s_axi_awvalid,   // Write address valid
    output logic             s_axi_awready,   // Write address ready
    input  wire logic [31:0] s_axi_wdata,     // Write data
    input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
    input  wire logic        s_axi_wvalid,    // Write data valid
    output logic             s_axi_wready,    // Write data ready
    output logic [1:0]       s_axi_bresp,     // Write response
    output logic             s_axi_bvalid,    // Write response valid
    input  wire logic        s_axi_bready,    // Write response ready
    input  wire logic [9:0]  s_axi_araddr,    // Read address
    input  wire logic        s_axi_arvalid,   // Read address valid
    output logic             s_axi_arready,   // Read address ready
    output logic [31:0]      s_axi_rdata,     // Read data
    output logic [1:0]       s_axi_rresp,     // Read response
    output logic             s_axi_rvalid,    // Read data valid
    input  wire logic        s_axi_rready,    // Read data ready
    input  wire logic        rc_tick,         // Internal RC clock period pulse
    input  wire logic [9:0]  sar_code,        // Raw code from the analog converter
    output logic             converter_on,    // Converter powered
    output logic             sample_hold,     // Acquisition switch closed
    output logic             convert_active,  // Successive approximation running
    output logic [1:0]       channel_sel,     // Analog mux select
    output logic             reference_source_sel, // High: external reference pin
    output logic [3:0]       pin_analog_sel,  // Per pin analog assignment
    output logic [7:0]       result_high_byte,// Result upper register
    output logic [7:0]       result_low_byte, // Result lower register
    output logic             irq              // Level interrupt
);
    typedef enum {S_OFF, S_ACQ, S_CONV, S_ABORT} conv_t;

    typedef struct packed
    {
        conv_t      cs;
        logic [3:0] periods;
        logic [7:0] ctrl;
        logic [7:0] pinclk;
        logic [9:0] code;
        logic       done_flag;
        logic       done_mask;
        logic       aw_got;
        logic [9:0] aw_addr;
        logic       w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic       irq;
    } adc_state_t;

    adc_state_t st_ff;
    adc_state_t nxt_st;
    logic       tick;
    logic       wr_fire;
    logic       rd_fire;
    logic [7:0] wbyte;

    // Divider restarts on abort so the wait spans two whole periods except with RC selected
    tad_divider u_div
    (
        .clk     (clk),
        .rst_b   (rst_b),
        .run     ((st_ff.cs == S_CONV && st_ff.ctrl[GO_BIT]) || st_ff.cs == S_ABORT),
        .clk_sel (st_ff.pinclk[CLKSEL_LSB +: 3]),
        .rc_tick (rc_tick),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // Register bus and converter sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        wbyte = st_ff.w_data[7:0];
        if (s_axi_awvalid && !st_ff.aw_got)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_got)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready)
            nxt_st.bvalid = 1'b0;
        if (st_ff.rvalid && s_axi_rready)
            nxt_st.rvalid = 1'b0;
        wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        rd_fire = s_axi_arvalid && !st_ff.rvalid;

        // Converter sequencing first so software writes override below
        case (st_ff.cs)
            S_OFF:
                if (st_ff.ctrl[ON_BIT])
                    nxt_st.cs = S_ACQ;
            S_ACQ:
                if (st_ff.ctrl[GO_BIT])
                begin
                    nxt_st.cs = S_CONV;
                    nxt_st.periods = 4'd0;
                end
            S_CONV:
                if (!st_ff.ctrl[GO_BIT])
                begin
                    nxt_st.cs = S_ABORT;
                    nxt_st.periods = 4'd0;
                end
                else if (tick)
                begin
                    nxt_st.periods = st_ff.periods + 4'd1;
                    if (st_ff.periods + 4'd1 == CONV_PERIODS)
                    begin
                        nxt_st.cs = S_ACQ;
                        nxt_st.code = sar_code;
                        nxt_st.ctrl[GO_BIT] = 1'b0;
                        nxt_st.done_flag = 1'b1;
                    end
                end
            S_ABORT:
                if (tick)
                begin
                    nxt_st.periods = st_ff.periods + 4'd1;
                    if (st_ff.periods + 4'd1 == ABORT_PERIODS)
                        nxt_st.cs = S_ACQ;
                end
            default:
                nxt_st.cs = S_OFF;
        endcase

        if (wr_fire)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = AXI_OKAY;
            if (st_ff.w_strb[0])
            begin
                case (st_ff.aw_addr)
                    CTRL_ADDR:
                        nxt_st.ctrl = wbyte & CTRL_WMASK;
                    PINCLK_ADDR:
                        nxt_st.pinclk = wbyte & PINCLK_WMASK;
                    IRQ_STATUS_ADDR:
                        if (wbyte[0] && !nxt_st.done_flag)
                            nxt_st.done_flag = 1'b0;
                        else if (wbyte[0] && st_ff.done_flag)
                            nxt_st.done_flag = 1'b0;
                    IRQ_MASK_ADDR:
                        nxt_st.done_mask = wbyte[0];
                    RESULT_ADDR:
                        nxt_st.bresp = AXI_OKAY;
                    default:
                        nxt_st.bresp = AXI_SLVERR;
                endcase
            end
            // A completion this very cycle must not be lost to the clear
            if (st_ff.cs == S_CONV && nxt_st.cs == S_ACQ && nxt_st.code == sar_code
                && st_ff.ctrl[GO_BIT] && tick && st_ff.periods + 4'd1 == CONV_PERIODS)
                nxt_st.done_flag = 1'b1;
        end

        if (rd_fire)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = AXI_OKAY;
            case (s_axi_araddr)
                CTRL_ADDR:       nxt_st.rdata = {24'h000000, st_ff.ctrl};
                PINCLK_ADDR:     nxt_st.rdata = {24'h000000, st_ff.pinclk};
                RESULT_ADDR:     nxt_st.rdata = {16'h0000, result_high_byte, result_low_byte};
                IRQ_STATUS_ADDR: nxt_st.rdata = {31'h0, st_ff.done_flag};
                IRQ_MASK_ADDR:   nxt_st.rdata = {31'h0, st_ff.done_mask};
                default:
                begin
                    nxt_st.rdata = 32'h00000000;
                    nxt_st.rresp = AXI_SLVERR;
                end
            endcase
        end

        if (!nxt_st.ctrl[ON_BIT])
        begin
            nxt_st.cs = S_OFF;
            nxt_st.ctrl[GO_BIT] = 1'b0;
        end
        nxt_st.irq = nxt_st.done_flag && nxt_st.done_mask;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '0;
            st_ff.cs <= S_OFF;
            st_ff.ctrl <= CTRL_RESET;
            st_ff.pinclk <= PINCLK_RESET;
        end
        else
            st_ff <= nxt_st;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = !st_ff.aw_got;
    assign s_axi_wready = !st_ff.w_got;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign converter_on = st_ff.ctrl[ON_BIT];
    assign sample_hold = (st_ff.cs == S_ACQ);
    assign convert_active = (st_ff.cs == S_CONV);
    assign channel_sel = st_ff.ctrl[CHAN_LSB +: 2];
    assign reference_source_sel = st_ff.ctrl[REF_BIT];
    assign pin_analog_sel = st_ff.pinclk[3:0];
    // Justification is applied at read time so a late change reformats the held result
    assign result_high_byte = st_ff.ctrl[JUSTIFY_BIT] ?
                              {6'h00, st_ff.code[9:8]} : st_ff.code[9:2];
    assign result_low_byte = st_ff.ctrl[JUSTIFY_BIT] ?
                             st_ff.code[7:0] : {st_ff.code[1:0], 6'h00};
    assign irq = st_ff.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_abort_keeps: assert property (@(posedge clk) disable iff (!rst_b)
        (st_ff.cs == S_CONV && !st_ff.ctrl[GO_BIT]) |=> $stable(st_ff.code))
        else $error("abort changed result");
    a_done_clears: assert property (@(posedge clk) disable iff (!rst_b)
        ($past(st_ff.cs) == S_CONV && st_ff.cs == S_ACQ && st_ff.ctrl[ON_BIT])
        |-> !st_ff.ctrl[GO_BIT] && st_ff.done_flag)
        else $error("completion did not clear go or set flag");
    a_conv_len: assert property (@(posedge clk) disable iff (!rst_b)
        (st_ff.cs == S_CONV && $past(st_ff.cs) == S_CONV && st_ff.cs != nxt_st.cs
         && nxt_st.cs == S_ACQ) |-> st_ff.periods == CONV_PERIODS - 4'd1)
        else $error("conversion length not eleven periods");
    a_abort_len: assert property (@(posedge clk) disable iff (!rst_b)
        (st_ff.cs == S_ABORT && nxt_st.cs == S_ACQ) |-> tick && st_ff.periods == 4'd1)
        else $error("abort wait not two periods");
    a_off_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !converter_on |-> !convert_active && !sample_hold)
        else $error("converter active while off");
    a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
        irq == (st_ff.done_flag && st_ff.done_mask))
        else $error("irq does not follow flag and mask");
    a_right_just: assert property (@(posedge clk) disable iff (!rst_b)
        st_ff.ctrl[JUSTIFY_BIT] |-> result_high_byte[7:2] == 6'h00)
        else $error("right justify upper bits set");
    a_left_just: assert property (@(posedge clk) disable iff (!rst_b)
        !st_ff.ctrl[JUSTIFY_BIT] |-> result_low_byte[5:0] == 6'h00)
        else $error("left justify lower bits set");
    a_chan_route: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(wr_fire) |-> $stable(channel_sel))
        else $error("channel select moved without a write");
endmodule

/* File: logic/tad_divider.sv */
// Conversion clock tick generator: oscillator divider or internal RC edge
`timescale 1ns/100ps
module tad_divider
    import adc_ctrl_pkg::*;
(
    input  wire logic       clk,       // System clock
    input  wire logic       rst_b,     // Async reset, active low
    input  wire logic       run,       // Count while high
    input  wire logic [2:0] clk_sel,   // Conversion clock select
    input  wire logic       rc_tick,   // Internal RC period tick
    output logic            tick       // One pulse per conversion period
);
    typedef struct packed
    {
        logic [5:0] cnt;
        logic       tick;
    } div_state_t;

    div_state_t st_ff;
    div_state_t nxt_st;
    logic [5:0] limit;

    always_comb
    begin
        case (clk_sel)
            3'b000:  limit = 6'd1;
            3'b100:  limit = 6'd3;
            3'b001:  limit = 6'd7;
            3'b101:  limit = 6'd15;
            3'b010:  limit = 6'd31;
            3'b110:  limit = 6'd63;
            default: limit = 6'd0;
        endcase
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!run)
        begin
            nxt_st.cnt = 6'd0;
        end
        else if (clk_sel[1:0] == 2'b11)
        begin
            nxt_st.tick = rc_tick;
        end
        else if (st_ff.cnt >= limit)
        begin
            nxt_st.cnt = 6'd0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 6'd1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tick = st_ff.tick;

    a_tick_divide: assert property (@(posedge clk) disable iff (!rst_b)
        (run && clk_sel == 3'b000 && $past(run) && $past(clk_sel) == 3'b000 && tick)
        |=> !tick ##1 (tick || !run || clk_sel != 3'b000))
        else $error("divide by two tick spacing wrong");
endmodule

/* File: shared/adc_ctrl_pkg.sv */
// Package: register map, field layout, reset values and timing for the converter control block
package adc_ctrl_pkg;
    // Printed offsets are not all multiples of four: kept as indices, byte address = 4 * index
    localparam logic [7:0]  CTRL_IDX         = 8'h1f;
    localparam logic [7:0]  PINCLK_IDX       = 8'h9f;
    localparam logic [7:0]  RESULT_IDX       = 8'h20;
    localparam logic [7:0]  IRQ_STATUS_IDX   = 8'h21;
    localparam logic [7:0]  IRQ_MASK_IDX     = 8'h22;
    localparam logic [9:0]  CTRL_ADDR        = {CTRL_IDX, 2'b00};
    localparam logic [9:0]  PINCLK_ADDR      = {PINCLK_IDX, 2'b00};
    localparam logic [9:0]  RESULT_ADDR      = {RESULT_IDX, 2'b00};
    localparam logic [9:0]  IRQ_STATUS_ADDR  = {IRQ_STATUS_IDX, 2'b00};
    localparam logic [9:0]  IRQ_MASK_ADDR    = {IRQ_MASK_IDX, 2'b00};
    // Control register fields
    localparam int          JUSTIFY_BIT      = 7;
    localparam int          REF_BIT          = 6;
    localparam int          CHAN_LSB         = 2;
    localparam int          GO_BIT           = 1;
    localparam int          ON_BIT           = 0;
    localparam logic [7:0]  CTRL_WMASK       = 8'hcf;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    // Pin / clock register fields
    localparam int          CLKSEL_LSB       = 4;
    localparam logic [7:0]  PINCLK_WMASK     = 8'h7f;
    localparam logic [7:0]  PINCLK_RESET     = 8'h0f;
    // Conversion timing in conversion clock periods
    localparam logic [3:0]  CONV_PERIODS     = 4'd11;
    localparam logic [3:0]  ABORT_PERIODS    = 4'd2;
    localparam logic [1:0]  AXI_OKAY         = 2'b00;
    localparam logic [1:0]  AXI_SLVERR       = 2'b10;
endpackage

/* File: testbench/test_adc_control.sv */
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, e, s); end end
module test_adc_control
    import adc_ctrl_pkg::*;
;
    logic        clk, rst_b, converter_on, sample_hold, convert_active;
    logic        rc_tick = 1'b0;
    logic        reference_source_sel, irq;
    logic [9:0]  s_axi_awaddr, s_axi_araddr, sar_code, code_m;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat, seed;
    logic [3:0]  s_axi_wstrb, pin_analog_sel, pin_direction_bits;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp, channel_sel;
    logic [7:0]  result_high_byte, result_low_byte, ctrl_m, pin_m;
    logic [15:0] exp_res;
    int          n_mismatch, checks, n, d;
    int          rc_cnt = 0;

    adc_control dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .rc_tick(rc_tick), .sar_code(sar_code),
        .converter_on(converter_on), .sample_hold(sample_hold),
        .convert_active(convert_active), .channel_sel(channel_sel),
        .reference_source_sel(reference_source_sel), .pin_analog_sel(pin_analog_sel),
        .result_high_byte(result_high_byte), .result_low_byte(result_low_byte), .irq(irq));

    // ----------------------------------------------------------------
    // Reference model helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] fmt(input logic [9:0] c, input logic right);
        return right ? {6'h00, c} : {c, 6'h00};
    endfunction
    function automatic int div(input logic [2:0] s);
        case (s)
            3'b000: return 2;
            3'b100: return 4;
            3'b001: return 8;
            3'b101: return 16;
            3'b010: return 32;
            3'b110: return 64;
            default: return 7;
        endcase
    endfunction

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Internal RC stand-in, free running with a 7 cycle period
    always @(posedge clk)
    begin
        rc_tick <= (rc_cnt == 6);
        rc_cnt  <= (rc_cnt == 6) ? 0 : rc_cnt + 1;
    end

    // ----------------------------------------------------------------
    // Bus master tasks: look at handshakes mid-cycle, act after the edge
    // ----------------------------------------------------------------
    task automatic wr(input logic [9:0] a, input logic [31:0] dat, output logic [1:0] r);
        logic ah, wh, bh;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge clk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) s_axi_bready <= 1'b0;
        end while (!bh);
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] dat, output logic [1:0] r);
        logic ah, rh;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge clk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid && s_axi_rready;
            dat = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) s_axi_rready <= 1'b0;
        end while (!rh);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sar_code} = '0;
        s_axi_wstrb = 4'hf;
        seed = 32'hb32ab0f4;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(CTRL_ADDR, rdat, resp); `CHK("ctrl reset", 32'h00, rdat)
        rd(PINCLK_ADDR, rdat, resp); `CHK("pinclk reset", 32'h0f, rdat)
        wr(CTRL_ADDR, 32'hffff_fffd, resp);
        rd(CTRL_ADDR, rdat, resp); `CHK("ctrl mask", 32'hcd, rdat)
        `CHK("ref sel", 1'b1, reference_source_sel)
        wr(PINCLK_ADDR, 32'hffff_ffff, resp);
        rd(PINCLK_ADDR, rdat, resp); `CHK("pinclk mask", 32'h7f, rdat)
        rd(10'h3f0, rdat, resp); `CHK("bad rd resp", AXI_SLVERR, resp)
        `CHK("bad rd data", 32'h0, rdat)
        wr(10'h3f0, 32'h1, resp); `CHK("bad wr resp", AXI_SLVERR, resp)
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            pin_m = {1'b0, i[2:0], seed[3:0]};
            ctrl_m = {i[0], i[2], 2'b00, i[1:0], 2'b01};
            wr(IRQ_MASK_ADDR, {31'h0, ~i[2]}, resp);
            // Every pin about to turn analog is made an input first
            pin_direction_bits = seed[7:4] | seed[3:0];
            wr(PINCLK_ADDR, {24'h0, pin_m}, resp);
            `CHK("pin sel", seed[3:0], pin_analog_sel)
            `CHK("pin dir", 4'h0, pin_analog_sel & ~pin_direction_bits)
            wr(CTRL_ADDR, {24'h0, ctrl_m}, resp);
            `CHK("channel", i[1:0], channel_sel)
            `CHK("ref", i[2], reference_source_sel)
            `CHK("on", 1'b1, converter_on)
            repeat (30) @(posedge clk);
            `CHK("acquire", 1'b1, sample_hold)
            code_m = seed[25:16];
            sar_code <= code_m;
            wr(CTRL_ADDR, {24'h0, ctrl_m | 8'h02}, resp);
            n = 0;
            // Active flag is not settled at this edge yet: look first at mid-cycle
            do
            begin
                @(negedge clk);
                n++;
            end while (convert_active === 1'b1 && n < 2000);
            d = div(i[2:0]);
            `CHK("conv time", 1'b1, (n + d + 4 >= 11 * d) && (n <= 12 * d))
            repeat (2) @(negedge clk);
            exp_res = fmt(code_m, i[0]);
            `CHK("res ports", exp_res, {result_high_byte, result_low_byte})
            `CHK("irq", ~i[2], irq)
            rd(CTRL_ADDR, rdat, resp); `CHK("go cleared", {24'h0, ctrl_m}, rdat)
            rd(RESULT_ADDR, rdat, resp); `CHK("res reg", {16'h0, exp_res}, rdat)
            rd(IRQ_STATUS_ADDR, rdat, resp); `CHK("flag", 32'h1, rdat)
            wr(IRQ_STATUS_ADDR, 32'h1, resp);
            rd(IRQ_STATUS_ADDR, rdat, resp); `CHK("flag clr", 32'h0, rdat)
            `CHK("irq clr", 1'b0, irq)
        end
        // Abort on the slowest divider, stale code must not reach the result
        wr(PINCLK_ADDR, 32'h65, resp);
        wr(CTRL_ADDR, 32'h85, resp);
        repeat (30) @(posedge clk);
        sar_code <= ~code_m;
        wr(CTRL_ADDR, 32'h87, resp);
        repeat (100) @(posedge clk);
        wr(CTRL_ADDR, 32'h85, resp);
        n = 0;
        while (sample_hold !== 1'b1 && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("abort wait", 1'b1, (n >= 110) && (n <= 132))
        `CHK("abort res", fmt(code_m, 1'b1), {result_high_byte, result_low_byte})
        rd(IRQ_STATUS_ADDR, rdat, resp); `CHK("abort flag", 32'h0, rdat)
        wr(CTRL_ADDR, 32'h02, resp);
        repeat (3) @(negedge clk);
        `CHK("off", 1'b0, converter_on)
        `CHK("off idle", 2'b00, {sample_hold, convert_active})
        give_verdict();
    end
endmodule
